// [src/crfoc_pkg.sv]
// Package with the constants, encodings and carrier types of the register file and operand core.
package crfoc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register file geometry and dedicated register indices.
    localparam int REG_COUNT = 16;
    localparam int DATA_W = 16;
    localparam int IDX_W = 4;
    localparam logic [3:0] IDX_PC = 4'h0;
    localparam logic [3:0] IDX_SP = 4'h1;
    localparam logic [3:0] IDX_SR = 4'h2;
    localparam logic [3:0] IDX_CG = 4'h3;
    localparam logic [15:0] REG_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Flag positions inside the status register.
    localparam int SR_C = 0;
    localparam int SR_Z = 1;
    localparam int SR_N = 2;
    localparam int SR_V = 8;
    localparam int BYTE_MSB = 7;
    localparam int WORD_MSB = 15;

    ////////////////////////////////////////////////////////////////////////////
    // Values and masks used by the operand path.
    localparam logic [15:0] CG_ZERO = 16'h0000;
    localparam logic [15:0] CG_ONE = 16'h0001;
    localparam logic [15:0] CG_TWO = 16'h0002;
    localparam logic [15:0] CG_FOUR = 16'h0004;
    localparam logic [15:0] CG_EIGHT = 16'h0008;
    localparam logic [15:0] CG_ALL = 16'hffff;
    localparam logic [15:0] BYTE_MASK = 16'h00ff;
    localparam logic [15:0] EVEN_MASK = 16'hfffe;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction word field codes.
    localparam logic [3:0] OP_MOV = 4'h4;
    localparam logic [3:0] OP_ADD = 4'h5;
    localparam logic [3:0] OP_ADDC = 4'h6;
    localparam logic [3:0] OP_SUBC = 4'h7;
    localparam logic [3:0] OP_SUB = 4'h8;
    localparam logic [3:0] OP_CMP = 4'h9;
    localparam logic [3:0] OP_DADD = 4'ha;
    localparam logic [3:0] OP_BIT = 4'hb;
    localparam logic [3:0] OP_BIC = 4'hc;
    localparam logic [3:0] OP_BIS = 4'hd;
    localparam logic [3:0] OP_XOR = 4'he;
    localparam logic [3:0] OP_AND = 4'hf;
    localparam logic [3:0] OP_RRC = 4'h0;
    localparam logic [3:0] OP_SWPB = 4'h1;
    localparam logic [3:0] OP_RRA = 4'h2;
    localparam logic [3:0] OP_SXT = 4'h3;
    localparam logic [3:0] OP_RETI = 4'h6;
    localparam logic [5:0] SINGLE_PREFIX = 6'h04;
    localparam logic [2:0] JUMP_PREFIX = 3'h1;
    localparam logic [1:0] AS_REG = 2'h0;
    localparam logic [1:0] AS_IDX = 2'h1;
    localparam logic [1:0] AS_IND = 2'h2;
    localparam logic [1:0] AS_INC = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Encodings and carrier types.
    typedef enum logic [1:0] {
        FMT_NONE = 2'h0,
        FMT_DUAL = 2'h1,
        FMT_SINGLE = 2'h3,
        FMT_JUMP = 2'h2
    } crfoc_fmt_t;

    typedef enum logic [2:0] {
        AM_REGISTER = 3'h0,
        AM_INDEXED = 3'h1,
        AM_SYMBOLIC = 3'h3,
        AM_ABSOLUTE = 3'h2,
        AM_INDIRECT = 3'h6,
        AM_AUTOINC = 3'h7,
        AM_IMMEDIATE = 3'h5,
        AM_CONST = 3'h4
    } crfoc_mode_t;

    typedef struct packed {
        logic legal;
        crfoc_fmt_t fmt;
        logic [3:0] op;
        logic [3:0] src_idx;
        logic [3:0] dst_idx;
        crfoc_mode_t src_mode;
        crfoc_mode_t dst_mode;
        logic [15:0] cg_value;
        logic byte_op;
    } crfoc_dec_t;

    typedef struct packed {
        logic v;
        logic n;
        logic z;
        logic c;
    } crfoc_flags_t;

endpackage : crfoc_pkg

// [src/crfoc_alu.sv]
// Combining unit that merges source and destination operands and derives the flags.
`timescale 1ns/1ps
module crfoc_alu (
    input wire crfoc_pkg::crfoc_dec_t dec_i,
    input wire logic [15:0] src_i,
    input wire logic [15:0] dst_i,
    input wire crfoc_pkg::crfoc_flags_t flags_i,
    output logic [15:0] result_o,
    output crfoc_pkg::crfoc_flags_t flags_o,
    output logic write_back_o,
    output logic flags_upd_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Decimal addition, one nibble at a time, with the carry out in bit 16.
    function automatic logic [16:0] crfoc_dadd(input logic [15:0] a, input logic [15:0] b, input logic cin,
                                               input logic byte_op);
        logic [4:0] nib;
        logic cy;
        logic [16:0] res;
        cy = cin;
        res = '0;
        for (int k = 0; k < 4; k++) begin
            nib = {1'b0, a[k*4 +: 4]} + {1'b0, b[k*4 +: 4]} + {4'h0, cy};
            if (nib > 5'h09) begin
                nib = nib + 5'h06;
            end
            res[k*4 +: 4] = nib[3:0];
            cy = nib[4];
            if (byte_op && (k == 1)) begin
                res[16] = cy;
            end
        end
        if (!byte_op) begin
            res[16] = cy;
        end
        return res;
    endfunction : crfoc_dadd

    ////////////////////////////////////////////////////////////////////////////
    // Width-dependent operands, sign bits and the binary sum.
    wire logic byte_op = dec_i.byte_op;
    wire logic [15:0] mask = byte_op ? crfoc_pkg::BYTE_MASK : crfoc_pkg::CG_ALL;
    wire logic [15:0] a = dst_i & mask;
    wire logic is_sub = (dec_i.op == crfoc_pkg::OP_SUB) || (dec_i.op == crfoc_pkg::OP_SUBC) ||
                        (dec_i.op == crfoc_pkg::OP_CMP);
    wire logic [15:0] b = (is_sub ? ~src_i : src_i) & mask;
    wire logic cin = (dec_i.op == crfoc_pkg::OP_SUB) || (dec_i.op == crfoc_pkg::OP_CMP) ? 1'b1 :
                     ((dec_i.op == crfoc_pkg::OP_ADDC) || (dec_i.op == crfoc_pkg::OP_SUBC)) ? flags_i.c : 1'b0;
    wire logic [16:0] sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    wire logic [16:0] dsum = crfoc_dadd(a, src_i & mask, flags_i.c, byte_op);
    wire logic msb_a = byte_op ? a[crfoc_pkg::BYTE_MSB] : a[crfoc_pkg::WORD_MSB];
    wire logic msb_b = byte_op ? b[crfoc_pkg::BYTE_MSB] : b[crfoc_pkg::WORD_MSB];
    wire logic sum_c = byte_op ? sum[crfoc_pkg::BYTE_MSB + 1] : sum[16];
    wire logic [15:0] sxt = {{8{dst_i[crfoc_pkg::BYTE_MSB]}}, dst_i[7:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Operation select; results are masked to the chosen width, except the single-operand SXT result.
    always_comb begin
        logic [15:0] r;
        logic c;
        logic v;
        logic arith;
        logic msb_r;
        r = dst_i;
        c = flags_i.c;
        v = 1'b0;
        arith = 1'b0;
        msb_r = 1'b0;
        write_back_o = 1'b0;
        flags_upd_o = 1'b0;
        if (dec_i.legal && (dec_i.fmt == crfoc_pkg::FMT_DUAL)) begin
            write_back_o = (dec_i.op != crfoc_pkg::OP_CMP) && (dec_i.op != crfoc_pkg::OP_BIT);
            flags_upd_o = (dec_i.op != crfoc_pkg::OP_MOV) && (dec_i.op != crfoc_pkg::OP_BIC) &&
                          (dec_i.op != crfoc_pkg::OP_BIS);
            case (dec_i.op)
                crfoc_pkg::OP_MOV: r = src_i;
                crfoc_pkg::OP_DADD: begin
                    r = dsum[15:0];
                    c = dsum[16];
                end
                crfoc_pkg::OP_BIT, crfoc_pkg::OP_AND: r = src_i & dst_i;
                crfoc_pkg::OP_BIC: r = ~src_i & dst_i;
                crfoc_pkg::OP_BIS: r = src_i | dst_i;
                crfoc_pkg::OP_XOR: r = src_i ^ dst_i;
                default: begin
                    r = sum[15:0];
                    c = sum_c;
                    arith = 1'b1;
                end
            endcase
        end else if (dec_i.legal && (dec_i.fmt == crfoc_pkg::FMT_SINGLE)) begin
            write_back_o = (dec_i.op <= crfoc_pkg::OP_SXT);
            flags_upd_o = write_back_o && (dec_i.op != crfoc_pkg::OP_SWPB);
            case (dec_i.op)
                crfoc_pkg::OP_RRC: r = {1'b0, a[15:1]} | (flags_i.c ? ~(mask >> 1) & mask : 16'h0000);
                crfoc_pkg::OP_RRA: r = {1'b0, a[15:1]} | (msb_a ? ~(mask >> 1) & mask : 16'h0000);
                crfoc_pkg::OP_SWPB: r = {dst_i[7:0], dst_i[15:8]};
                default: r = sxt;
            endcase
            if ((dec_i.op == crfoc_pkg::OP_RRC) || (dec_i.op == crfoc_pkg::OP_RRA)) begin
                c = dst_i[0];
            end
        end
        r = (dec_i.op == crfoc_pkg::OP_SXT) && (dec_i.fmt == crfoc_pkg::FMT_SINGLE) ? r : r & mask;
        msb_r = byte_op ? r[crfoc_pkg::BYTE_MSB] : r[crfoc_pkg::WORD_MSB];
        if (arith) begin
            v = (msb_a == msb_b) && (msb_r != msb_a);
        end else if ((dec_i.op == crfoc_pkg::OP_XOR) && (dec_i.fmt == crfoc_pkg::FMT_DUAL)) begin
            v = msb_a && (byte_op ? src_i[crfoc_pkg::BYTE_MSB] : src_i[crfoc_pkg::WORD_MSB]);
        end
        if ((dec_i.fmt == crfoc_pkg::FMT_DUAL) && ((dec_i.op == crfoc_pkg::OP_AND) ||
            (dec_i.op == crfoc_pkg::OP_BIT) || (dec_i.op == crfoc_pkg::OP_XOR))) begin
            c = (r != 16'h0000);
        end else if ((dec_i.fmt == crfoc_pkg::FMT_SINGLE) && (dec_i.op == crfoc_pkg::OP_SXT)) begin
            c = (r != 16'h0000);
        end
        result_o = r;
        flags_o.c = c;
        flags_o.z = (r == 16'h0000);
        flags_o.n = (dec_i.fmt == crfoc_pkg::FMT_SINGLE) && (dec_i.op == crfoc_pkg::OP_SXT) ?
                    r[crfoc_pkg::WORD_MSB] : msb_r;
        flags_o.v = v;
    end

endmodule : crfoc_alu

// [src/crfoc_core.sv]
// Sixteen-entry register file with instruction decode, operand selection and write-back.
//
// Behaviour
// (RL1) Sixteen registers, sixteen bits, four-bit index.
// (RL2) Register-to-register operation completes in one cycle.
// (RL3) Indices zero to three: PC, SP, flags, constants.
// (RL4) Indices four to fifteen are plain storage.
// (RL5) Seven source modes, four destination modes.
// (RL6) Decode 51 instructions in three formats.
// (RL7) Word or byte width on every instruction; jumps here take no width bit.
// (RL8) Operations are register operations plus addressing modes.
// (RL9) Memory and peripherals share one bus path.
// (RL10) Dual operand: combine, write to destination.
// (RL11) Byte register write clears the upper byte.
`timescale 1ns/1ps
module crfoc_core (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic [15:0] INSTR_I,
    input wire logic EXEC_I,
    input wire logic [15:0] SRC_MEM_I,
    input wire logic [15:0] DST_MEM_I,
    input wire logic WR_EN_I,
    input wire logic [3:0] WR_IDX_I,
    input wire logic [15:0] WR_DATA_I,
    input wire logic WR_BYTE_I,
    input wire logic [3:0] RD_IDX_I,
    output logic [15:0] RD_DATA_O,
    output logic INSTR_LEGAL_O,
    output crfoc_pkg::crfoc_fmt_t FORMAT_O,
    output crfoc_pkg::crfoc_mode_t SRC_MODE_O,
    output crfoc_pkg::crfoc_mode_t DST_MODE_O,
    output logic BYTE_OP_O,
    output logic [15:0] SRC_OPERAND_O,
    output logic [15:0] DST_OPERAND_O,
    output logic [15:0] PC_O,
    output logic [15:0] SP_O,
    output crfoc_pkg::crfoc_flags_t FLAGS_O,
    output logic BUS_WR_O,
    output logic BUS_BYTE_O,
    output logic [15:0] BUS_DATA_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Source mode from the As field and register; PC and the constant sources reinterpret modes.
    function automatic crfoc_pkg::crfoc_mode_t crfoc_src_mode(input logic [1:0] as_f, input logic [3:0] idx);
        crfoc_pkg::crfoc_mode_t m;
        case (as_f)
            crfoc_pkg::AS_REG: m = crfoc_pkg::AM_REGISTER;
            crfoc_pkg::AS_IDX: m = crfoc_pkg::AM_INDEXED;
            crfoc_pkg::AS_IND: m = crfoc_pkg::AM_INDIRECT;
            default: m = crfoc_pkg::AM_AUTOINC;
        endcase
        if (idx == crfoc_pkg::IDX_CG) begin
            m = crfoc_pkg::AM_CONST; // RL3
        end else if (idx == crfoc_pkg::IDX_SR) begin
            m = (as_f == crfoc_pkg::AS_REG) ? crfoc_pkg::AM_REGISTER :
                (as_f == crfoc_pkg::AS_IDX) ? crfoc_pkg::AM_ABSOLUTE : crfoc_pkg::AM_CONST;
        end else if ((idx == crfoc_pkg::IDX_PC) && (as_f == crfoc_pkg::AS_IDX)) begin
            m = crfoc_pkg::AM_SYMBOLIC;
        end else if ((idx == crfoc_pkg::IDX_PC) && (as_f == crfoc_pkg::AS_INC)) begin
            m = crfoc_pkg::AM_IMMEDIATE;
        end
        return m;
    endfunction : crfoc_src_mode

    ////////////////////////////////////////////////////////////////////////////
    // Destination mode: register, indexed, symbolic or absolute only.
    function automatic crfoc_pkg::crfoc_mode_t crfoc_dst_mode(input logic ad, input logic [3:0] idx);
        crfoc_pkg::crfoc_mode_t m;
        m = crfoc_pkg::AM_REGISTER;
        if (ad) begin
            m = (idx == crfoc_pkg::IDX_PC) ? crfoc_pkg::AM_SYMBOLIC :
                (idx == crfoc_pkg::IDX_SR) ? crfoc_pkg::AM_ABSOLUTE : crfoc_pkg::AM_INDEXED; // RL5
        end
        return m;
    endfunction : crfoc_dst_mode

    ////////////////////////////////////////////////////////////////////////////
    // Constant produced by the two constant sources.
    function automatic logic [15:0] crfoc_cg(input logic [1:0] as_f, input logic [3:0] idx);
        logic [15:0] v;
        v = crfoc_pkg::CG_ZERO;
        if (idx == crfoc_pkg::IDX_SR) begin
            v = (as_f == crfoc_pkg::AS_IND) ? crfoc_pkg::CG_FOUR : crfoc_pkg::CG_EIGHT;
        end else begin
            case (as_f)
                crfoc_pkg::AS_REG: v = crfoc_pkg::CG_ZERO;
                crfoc_pkg::AS_IDX: v = crfoc_pkg::CG_ONE;
                crfoc_pkg::AS_IND: v = crfoc_pkg::CG_TWO;
                default: v = crfoc_pkg::CG_ALL;
            endcase
        end
        return v;
    endfunction : crfoc_cg

    ////////////////////////////////////////////////////////////////////////////
    // Byte-aware register store: a byte write keeps the low byte and zeroes the rest.
    function automatic logic [15:0] crfoc_store(input logic [15:0] d, input logic byte_op, input logic [3:0] idx);
        logic [15:0] v;
        v = byte_op ? (d & crfoc_pkg::BYTE_MASK) : d; // RL11 RL7
        if ((idx == crfoc_pkg::IDX_PC) || (idx == crfoc_pkg::IDX_SP)) begin
            v = v & crfoc_pkg::EVEN_MASK;
        end
        return v;
    endfunction : crfoc_store

    ////////////////////////////////////////////////////////////////////////////
    // Storage and the decode of the instruction at the decoder port.
    logic [15:0] regs [crfoc_pkg::REG_COUNT]; // RL1
    logic [15:0] next_regs [crfoc_pkg::REG_COUNT];
    logic bus_wr;
    logic bus_byte;
    logic [15:0] bus_data;
    crfoc_pkg::crfoc_dec_t dec;
    wire logic [15:0] alu_result;
    wire crfoc_pkg::crfoc_flags_t alu_flags;
    wire logic alu_wb;
    wire logic alu_fupd;

    always_comb begin
        dec = '0;
        dec.fmt = crfoc_pkg::FMT_NONE;
        dec.src_mode = crfoc_pkg::AM_REGISTER;
        dec.dst_mode = crfoc_pkg::AM_REGISTER;
        if (INSTR_I[15:12] >= crfoc_pkg::OP_MOV) begin
            dec.legal = 1'b1; // RL6
            dec.fmt = crfoc_pkg::FMT_DUAL;
            dec.op = INSTR_I[15:12];
            dec.src_idx = INSTR_I[11:8];
            dec.dst_idx = INSTR_I[3:0];
            dec.src_mode = crfoc_src_mode(INSTR_I[5:4], INSTR_I[11:8]);
            dec.dst_mode = crfoc_dst_mode(INSTR_I[7], INSTR_I[3:0]);
            dec.cg_value = crfoc_cg(INSTR_I[5:4], INSTR_I[11:8]);
            dec.byte_op = INSTR_I[6];
        end else if (INSTR_I[15:13] == crfoc_pkg::JUMP_PREFIX) begin
            dec.legal = 1'b1; // RL6
            dec.fmt = crfoc_pkg::FMT_JUMP;
            dec.op = {1'b0, INSTR_I[12:10]};
        end else if ((INSTR_I[15:10] == crfoc_pkg::SINGLE_PREFIX) && ({1'b0, INSTR_I[9:7]} <= crfoc_pkg::OP_RETI)) begin
            dec.legal = 1'b1; // RL6
            dec.fmt = crfoc_pkg::FMT_SINGLE;
            dec.op = {1'b0, INSTR_I[9:7]};
            dec.src_idx = INSTR_I[3:0];
            dec.dst_idx = INSTR_I[3:0];
            dec.src_mode = crfoc_src_mode(INSTR_I[5:4], INSTR_I[3:0]);
            dec.dst_mode = dec.src_mode;
            dec.cg_value = crfoc_cg(INSTR_I[5:4], INSTR_I[3:0]);
            dec.byte_op = INSTR_I[6];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand selection: registers, constant sources, or the word fetched over the bus.
    wire logic [15:0] width_mask = dec.byte_op ? crfoc_pkg::BYTE_MASK : crfoc_pkg::CG_ALL; // RL7
    wire logic [15:0] src_raw = (dec.src_mode == crfoc_pkg::AM_REGISTER) ? regs[dec.src_idx] :
                                (dec.src_mode == crfoc_pkg::AM_CONST) ? dec.cg_value : SRC_MEM_I; // RL8 RL9
    wire logic dst_is_reg = (dec.fmt == crfoc_pkg::FMT_SINGLE) ? (dec.src_mode == crfoc_pkg::AM_REGISTER) :
                            (dec.dst_mode == crfoc_pkg::AM_REGISTER);
    wire logic [15:0] dst_raw = dst_is_reg ? regs[dec.dst_idx] : DST_MEM_I; // RL8 RL9
    wire logic [15:0] src_op = src_raw & width_mask;
    wire logic [15:0] dst_op = (dec.fmt == crfoc_pkg::FMT_SINGLE) && (dec.op == crfoc_pkg::OP_SWPB) ? dst_raw :
                               (dec.fmt == crfoc_pkg::FMT_SINGLE) && (dec.op == crfoc_pkg::OP_SXT) ? dst_raw :
                               dst_raw & width_mask;
    wire crfoc_pkg::crfoc_flags_t sr_flags = '{v: regs[crfoc_pkg::IDX_SR][crfoc_pkg::SR_V],
                                               n: regs[crfoc_pkg::IDX_SR][crfoc_pkg::SR_N],
                                               z: regs[crfoc_pkg::IDX_SR][crfoc_pkg::SR_Z],
                                               c: regs[crfoc_pkg::IDX_SR][crfoc_pkg::SR_C]};
    wire logic run = EXEC_I && dec.legal;
    wire logic reg_wb = run && alu_wb && dst_is_reg && (dec.dst_idx != crfoc_pkg::IDX_CG); // RL10 RL2
    wire logic mem_wb = run && alu_wb && !dst_is_reg; // RL9
    wire logic src_inc = run && (dec.src_mode == crfoc_pkg::AM_AUTOINC);
    wire logic [15:0] inc_step = (dec.byte_op && (dec.src_idx != crfoc_pkg::IDX_SP)) ?
                                 crfoc_pkg::STEP_BYTE : crfoc_pkg::STEP_WORD;

    crfoc_alu u_alu (
        .dec_i(dec),
        .src_i(src_op),
        .dst_i(dst_op),
        .flags_i(sr_flags),
        .result_o(alu_result),
        .flags_o(alu_flags),
        .write_back_o(alu_wb),
        .flags_upd_o(alu_fupd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next register values; execution write-back outranks the side write port.
    always_comb begin
        for (int i = 0; i < crfoc_pkg::REG_COUNT; i++) begin
            next_regs[i] = regs[i]; // RL4
        end
        if (WR_EN_I && (WR_IDX_I != crfoc_pkg::IDX_CG)) begin
            next_regs[WR_IDX_I] = crfoc_store(WR_DATA_I, WR_BYTE_I, WR_IDX_I); // RL11
        end
        if (src_inc) begin
            next_regs[dec.src_idx] = regs[dec.src_idx] + inc_step; // RL5
        end
        if (run && alu_fupd) begin
            next_regs[crfoc_pkg::IDX_SR][crfoc_pkg::SR_C] = alu_flags.c; // RL3
            next_regs[crfoc_pkg::IDX_SR][crfoc_pkg::SR_Z] = alu_flags.z;
            next_regs[crfoc_pkg::IDX_SR][crfoc_pkg::SR_N] = alu_flags.n;
            next_regs[crfoc_pkg::IDX_SR][crfoc_pkg::SR_V] = alu_flags.v;
        end
        if (reg_wb) begin
            next_regs[dec.dst_idx] = crfoc_store(alu_result, dec.byte_op, dec.dst_idx); // RL10 RL11 RL2
        end
        next_regs[crfoc_pkg::IDX_CG] = crfoc_pkg::REG_RESET; // RL3
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file and store-port flip-flops.
    always_ff @(posedge CLOCK_I) begin
        for (int i = 0; i < crfoc_pkg::REG_COUNT; i++) begin
            regs[i] <= RST_N_I ? next_regs[i] : crfoc_pkg::REG_RESET; // RL2
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            bus_wr <= 1'b0;
            bus_byte <= 1'b0;
            bus_data <= crfoc_pkg::REG_RESET;
        end else begin
            bus_wr <= mem_wb; // RL9
            bus_byte <= mem_wb ? dec.byte_op : bus_byte;
            bus_data <= mem_wb ? alu_result : bus_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs toward the decode and execute logic and the shared bus.
    assign RD_DATA_O = regs[RD_IDX_I];
    assign INSTR_LEGAL_O = dec.legal;
    assign FORMAT_O = dec.fmt;
    assign SRC_MODE_O = dec.src_mode;
    assign DST_MODE_O = dec.dst_mode;
    assign BYTE_OP_O = dec.byte_op;
    assign SRC_OPERAND_O = src_op;
    assign DST_OPERAND_O = dst_op;
    assign PC_O = regs[crfoc_pkg::IDX_PC]; // RL3
    assign SP_O = regs[crfoc_pkg::IDX_SP]; // RL3
    assign FLAGS_O = sr_flags;
    assign BUS_WR_O = bus_wr;
    assign BUS_BYTE_O = bus_byte;
    assign BUS_DATA_O = bus_data;

endmodule : crfoc_core

// [sim/crfoc_assertions.sv]
// Port checks for the register file and operand core.
`timescale 1ns/1ps
module crfoc_assertions (
    input logic CLOCK_I,
    input logic RST_N_I,
    input logic [15:0] INSTR_I,
    input logic EXEC_I,
    input logic WR_EN_I,
    input logic [3:0] WR_IDX_I,
    input logic [15:0] WR_DATA_I,
    input logic WR_BYTE_I,
    input logic [3:0] RD_IDX_I,
    input logic [15:0] RD_DATA_O,
    input logic INSTR_LEGAL_O,
    input crfoc_pkg::crfoc_fmt_t FORMAT_O,
    input crfoc_pkg::crfoc_mode_t DST_MODE_O,
    input logic [15:0] PC_O,
    input logic [15:0] SP_O,
    input logic BUS_WR_O
);
    ////////////////////////////////////////////////////////////////////////////
    // All checks use the core clock and rest while reset is low.
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    chk_const_zero: assert property (RD_IDX_I == 4'h3 |-> RD_DATA_O == 16'h0000) else $error("R3 not zero.");
    chk_ptr_even: assert property (PC_O[0] == 1'b0 && SP_O[0] == 1'b0) else $error("Odd pointer.");
    chk_side_store: assert property (WR_EN_I && !EXEC_I && WR_IDX_I > 4'h3 && RD_IDX_I == WR_IDX_I |=>
        !$stable(RD_IDX_I) || RD_DATA_O == ($past(WR_BYTE_I) ? $past(WR_DATA_I) & 16'h00ff : $past(WR_DATA_I)))
        else $error("Side write lost.");
    chk_byte_upper: assert property (WR_EN_I && WR_BYTE_I && !EXEC_I && RD_IDX_I == WR_IDX_I |=>
        !$stable(RD_IDX_I) || RD_DATA_O[15:8] == 8'h00) else $error("Upper byte kept.");
    chk_legal_fmt: assert property (INSTR_LEGAL_O == (FORMAT_O != crfoc_pkg::FMT_NONE)) else $error("Legal bad.");
    chk_dual_decode: assert property (INSTR_I[15:14] != 2'h0 |-> FORMAT_O == crfoc_pkg::FMT_DUAL)
        else $error("Dual not decoded.");
    chk_jump_decode: assert property (INSTR_I[15:13] == 3'h1 |-> FORMAT_O == crfoc_pkg::FMT_JUMP)
        else $error("Jump not decoded.");
    chk_dst_modes: assert property (FORMAT_O == crfoc_pkg::FMT_DUAL |-> (INSTR_I[7] ?
        (DST_MODE_O inside {3'h1, 3'h2, 3'h3}) : DST_MODE_O == crfoc_pkg::AM_REGISTER))
        else $error("Bad destination mode.");
    chk_bus_cause: assert property (BUS_WR_O |-> $past(EXEC_I) && $past(INSTR_LEGAL_O))
        else $error("Stray store.");
    // Main scenarios.
    cov_store: cover property (BUS_WR_O);
    cov_exec: cover property (EXEC_I && INSTR_LEGAL_O);
    cov_byte_wr: cover property (WR_EN_I && WR_BYTE_I);
endmodule : crfoc_assertions
bind crfoc_core crfoc_assertions u_chk (.*);

// [sim/crfoc_partner.sv]
// Memory and peripheral responder that feeds operand words to the core.
`timescale 1ns/1ps
module crfoc_partner (
    input logic clk_i,
    input logic rst_n_i,
    output logic [15:0] src_mem_o,
    output logic [15:0] dst_mem_o
);
    // Words change every cycle, though the source word alternates between two values and repeats every second cycle.
    always_ff @(posedge clk_i) begin
        src_mem_o <= rst_n_i ? ~src_mem_o + 16'h0003 : 16'h1234;
        dst_mem_o <= rst_n_i ? dst_mem_o + 16'h6b3d : 16'h5a3c;
    end
endmodule : crfoc_partner

// [sim/tb_cpu_register_file_operand_core.sv]
// Self-checking bench for the register file and operand core.
`timescale 1ns/1ps
module tb_cpu_register_file_operand_core;
    logic CLOCK_I, RST_N_I, EXEC_I, WR_EN_I, WR_BYTE_I, INSTR_LEGAL_O, BUS_WR_O, m;
    logic [3:0] WR_IDX_I, RD_IDX_I, FLAGS_O;
    logic [15:0] INSTR_I, SRC_MEM_I, DST_MEM_I, WR_DATA_I, RD_DATA_O, BUS_DATA_O, exp_v;
    logic [1:0] f;
    logic [2:0] s, d;
    crfoc_pkg::crfoc_fmt_t FORMAT_O;
    crfoc_pkg::crfoc_mode_t SRC_MODE_O, DST_MODE_O;
    logic [15:0] mdl [16];
    logic [31:0] seed;
    int num_errors, checks, i;
    logic [31:0] cg [5] = '{32'h43160001, 32'h4336ffff, 32'h437600ff, 32'h42260004, 32'h42360008};
    logic [24:0] tbl [12] = '{25'ha80a80, 25'ha82a91, 25'ha84ae1, 25'ha86af1, 25'ha92a93, 25'h8060d1, 25'h8020b1,
        25'h8520a7, 25'h8704c5, 25'h400100, 25'h200180, 25'h000000};
    crfoc_core dut (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .INSTR_I(INSTR_I), .EXEC_I(EXEC_I),
        .SRC_MEM_I(SRC_MEM_I), .DST_MEM_I(DST_MEM_I), .WR_EN_I(WR_EN_I), .WR_IDX_I(WR_IDX_I),
        .WR_DATA_I(WR_DATA_I), .WR_BYTE_I(WR_BYTE_I), .RD_IDX_I(RD_IDX_I), .RD_DATA_O(RD_DATA_O),
        .INSTR_LEGAL_O(INSTR_LEGAL_O), .FORMAT_O(FORMAT_O), .SRC_MODE_O(SRC_MODE_O), .DST_MODE_O(DST_MODE_O),
        .BYTE_OP_O(), .SRC_OPERAND_O(), .DST_OPERAND_O(), .PC_O(), .SP_O(), .FLAGS_O(FLAGS_O),
        .BUS_WR_O(BUS_WR_O), .BUS_BYTE_O(), .BUS_DATA_O(BUS_DATA_O));
    crfoc_partner partner (.clk_i(CLOCK_I), .rst_n_i(RST_N_I), .src_mem_o(SRC_MEM_I), .dst_mem_o(DST_MEM_I));
    ////////////////////////////////////////////////////////////////////////////
    // Helper tasks and the random source.
    task automatic close_out();
        if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic chk(input string name, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic cyc();
        @(posedge CLOCK_I);
        #1;
    endtask : cyc
    // Side write; the model mirrors the store rules.
    task automatic wr(input logic [3:0] idx, input logic [15:0] v, input logic b);
        {WR_EN_I, WR_IDX_I, WR_DATA_I, WR_BYTE_I} = {1'b1, idx, v, b};
        cyc();
        mdl[idx] = (idx == 4'h3) ? 16'h0000 : v & (b ? 16'h00ff : 16'hffff) & (idx < 4'h2 ? 16'hfffe : 16'hffff);
    endtask : wr
    task automatic rd(input logic [3:0] idx);
        RD_IDX_I = idx;
        #1;
        chk("rd_data", mdl[idx], RD_DATA_O);
        cyc();
    endtask : rd
    task automatic ex(input logic [15:0] ins);
        {INSTR_I, EXEC_I} = {ins, 1'b1};
        cyc();
    endtask : ex
    ////////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and the main sequence.
    initial begin
        CLOCK_I = 1'b0;
        forever #2 CLOCK_I = ~CLOCK_I;
    end
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
    initial begin
        {RST_N_I, EXEC_I, WR_EN_I, WR_BYTE_I, WR_IDX_I, RD_IDX_I, INSTR_I, WR_DATA_I} = '0;
        seed = 32'hd9254e6d;
        mdl = '{default: 16'h0000};
        repeat (8) @(posedge CLOCK_I);
        #1;
        RST_N_I = 1'b1;
        for (i = 0; i < 16; i++) rd(i[3:0]);
        for (i = 0; i < 48; i++) begin
            seed = lfsr(seed);
            wr(seed[19:16], seed[15:0], seed[20]);
        end
        WR_EN_I = 1'b0;
        for (i = 0; i < 16; i++) rd(i[3:0]);
        ex(16'h5405);
        mdl[5] = mdl[4] + mdl[5];
        ex(16'h5445);
        mdl[5] = (mdl[4] + mdl[5]) & 16'h00ff;
        ex(16'h0000);
        EXEC_I = 1'b0;
        rd(4'h5);
        for (i = 0; i < 5; i++) begin
            ex(cg[i][31:16]);
            EXEC_I = 1'b0;
            mdl[6] = cg[i][15:0];
            rd(4'h6);
        end
        ex(16'he606);
        chk("flags", 16'h0002, {12'h0, FLAGS_O});
        exp_v = mdl[4] + DST_MEM_I;
        ex(16'h5485);
        EXEC_I = 1'b0;
        chk("bus_wr", 16'h0001, {15'h0, BUS_WR_O});
        chk("bus_data", exp_v, BUS_DATA_O);
        rd(4'h5);
        chk("bus_wr", 16'h0000, {15'h0, BUS_WR_O});
        for (i = 0; i < 12; i++) begin
            {INSTR_I, f, s, d, m} = tbl[i];
            #1;
            chk("format", {14'h0, f}, {14'h0, FORMAT_O});
            chk("legal", {15'h0, f != 2'h0}, {15'h0, INSTR_LEGAL_O});
            if (m) chk("src_mode", {13'h0, s}, {13'h0, SRC_MODE_O});
            if (m) chk("dst_mode", {13'h0, d}, {13'h0, DST_MODE_O});
            cyc();
        end
        close_out();
    end
endmodule : tb_cpu_register_file_operand_core
